// [hdl/sifm_pkg.sv]
// Operation
// [R1] Magnitude of each signed select, -37 to 37, picks the function fed.
// [R2] Positive select: conducting input reads ON; negative select inverts it.
// [R3] Inputs selecting the same function are ORed together.
// [R4] Functions no input selects read OFF unless forced.
// [R5] An active force bit drives its function ON, overriding everything else.
// [R6] Selects reset to codes 4, 3, 23, 0 and 0.
// [R7] Used travel limit permits motion only while its input is ON.
// [R8] Limit ignore: 0 both used, 1 forward ignored, 2 reverse ignored, 3 both.
// [R9] An ignored limit allows motion whatever its signal does.
// [R10] Enable source: 0 follows servo-on function, 1 enables by software.
// [R11] Enable source honoured only while the override setting is 0.
// [R12] Each fast input has a filter enable, 0 bypass, 1 filter, reset 0; filtered_inputs always takes the filtered level.
// [R13] Input one filter time in 0.1 ms steps, default 2.0 ms.
// [R14] Force mask bits 4..0: reverse, forward, alarm reset, servo-on, unused.
// [R15] Smaller filter time responds faster; larger rejects more noise.
// [R16] Raw inputs are filtered before polarity, OR-combining and forcing.
package sifm_pkg;

   localparam int SIFM_CLK_PERIOD_NS = 10;
   localparam int SIFM_TICK_NS = 100000;
   localparam int SIFM_TICK_CYCLES = SIFM_TICK_NS / SIFM_CLK_PERIOD_NS;
   localparam int SIFM_FAST_FILT_NS = 40;
   localparam int SIFM_FAST_FILT_CYCLES =
      (SIFM_FAST_FILT_NS + SIFM_CLK_PERIOD_NS - 1) / SIFM_CLK_PERIOD_NS;

   localparam int SIFM_NUM_INPUTS = 5;
   localparam int SIFM_NUM_FUNCS = 38;
   localparam int SIFM_SEL_W = 7;
   localparam int SIFM_CODE_W = 6;
   localparam int SIFM_FTIME_W = 10;

   // Register byte offsets
   localparam logic [7:0] SIFM_OFS_SEL_BASE = 8'h00;
   localparam logic [7:0] SIFM_OFS_LIMIT_IGNORE = 8'h14;
   localparam logic [7:0] SIFM_OFS_ENABLE_SOURCE = 8'h18;
   localparam logic [7:0] SIFM_OFS_ENABLE_OVERRIDE = 8'h1c;
   localparam logic [7:0] SIFM_OFS_FAST_FILTER_EN = 8'h20;
   localparam logic [7:0] SIFM_OFS_FILTER_TIME = 8'h24;
   localparam logic [7:0] SIFM_OFS_FORCE_MASK = 8'h28;
   localparam logic [7:0] SIFM_OFS_STATUS = 8'h2c;
   localparam logic [7:0] SIFM_OFS_FUNC_LOW = 8'h30;
   localparam logic [7:0] SIFM_OFS_FUNC_HIGH = 8'h34;

   // Reset values
   localparam logic [6:0] SIFM_RST_SEL1 = 7'h04;
   localparam logic [6:0] SIFM_RST_SEL2 = 7'h03;
   localparam logic [6:0] SIFM_RST_SEL3 = 7'h17;
   localparam logic [6:0] SIFM_RST_SEL4 = 7'h00;
   localparam logic [6:0] SIFM_RST_SEL5 = 7'h00;
   localparam logic [1:0] SIFM_RST_LIMIT_IGNORE = 2'h3;
   localparam logic SIFM_RST_ENABLE_SOURCE = 1'b0;
   localparam logic SIFM_RST_ENABLE_OVERRIDE = 1'b0;
   localparam logic [1:0] SIFM_RST_FAST_FILTER_EN = 2'h0;
   localparam logic [9:0] SIFM_RST_FILTER_TIME = 10'h014;
   localparam logic [4:0] SIFM_RST_FORCE_MASK = 5'h00;

   // Legal ranges
   localparam logic [5:0] SIFM_SEL_MAX = 6'h25;
   localparam logic [9:0] SIFM_FILTER_TIME_MIN = 10'h001;
   localparam logic [9:0] SIFM_FILTER_TIME_MAX = 10'h3e8;

   // Function codes
   localparam logic [5:0] SIFM_FN_SERVO_ON = 6'h01;
   localparam logic [5:0] SIFM_FN_ALARM_RESET = 6'h02;
   localparam logic [5:0] SIFM_FN_FWD_LIMIT = 6'h03;
   localparam logic [5:0] SIFM_FN_REV_LIMIT = 6'h04;

   // Force mask bit positions
   localparam int SIFM_FORCE_SERVO_ON_BIT = 1;
   localparam int SIFM_FORCE_ALARM_RESET_BIT = 2;
   localparam int SIFM_FORCE_FWD_LIMIT_BIT = 3;
   localparam int SIFM_FORCE_REV_LIMIT_BIT = 4;

   // Limit ignore bit positions
   localparam int SIFM_IGNORE_FWD_BIT = 0;
   localparam int SIFM_IGNORE_REV_BIT = 1;

   typedef struct packed {
      logic reverse_allow;
      logic forward_allow;
      logic alarm_reset;
      logic servo_enable;
   } sifm_motion_type;

   typedef struct packed {
      logic [1:0] fast;
      logic [4:0] general;
   } sifm_inputs_type;

endpackage

// [hdl/sifm_mapper.sv]
module sifm_mapper
   import sifm_pkg::*;
#(
   parameter int TICK_CYCLES = SIFM_TICK_CYCLES
)
(
   input wire logic ref_clk,
   input wire logic sys_rst,
   input wire logic [7:0] avs_address,
   input wire logic avs_read,
   input wire logic avs_write,
   input wire logic [31:0] avs_writedata,
   input wire logic [3:0] avs_byteenable,
   output logic [31:0] avs_readdata,
   output logic avs_waitrequest,
   input wire logic [4:0] general_input_raw,
   input wire logic fast_input_one,
   input wire logic fast_input_two,
   output logic fast_input_one_out,
   output logic fast_input_two_out,
   output sifm_inputs_type filtered_inputs,
   output sifm_motion_type motion,
   output logic [37:0] function_state
);

   localparam int TICK_W = $clog2(TICK_CYCLES + 1);
   localparam int FAST_W = $clog2(SIFM_FAST_FILT_CYCLES + 1);

   // Settings
   logic [6:0] func_select [SIFM_NUM_INPUTS];
   logic [1:0] limit_ignore_select;
   logic enable_source_select;
   logic enable_source_override;
   logic [1:0] fast_filter_enable;
   logic [9:0] input_one_filter_time;
   logic [4:0] function_force_mask_one;

   // Bus decode
   logic bus_req;
   logic bus_take;
   logic [31:0] next_readdata;
   logic sel_hit;
   logic [2:0] sel_index;

   assign bus_req = avs_read | avs_write;
   assign bus_take = avs_write & ~avs_waitrequest;
   assign sel_index = avs_address[4:2];
   assign sel_hit = (avs_address[1:0] == 2'h0) &&
                    (avs_address < SIFM_OFS_LIMIT_IGNORE);

   // Request seen with waitrequest high, answered the next cycle
   always_ff @(posedge ref_clk)
   begin
      if (sys_rst)
      begin
         avs_waitrequest <= 1'b1;
         avs_readdata <= 32'h0000_0000;
      end
      else if (bus_req && avs_waitrequest)
      begin
         avs_waitrequest <= 1'b0;
         avs_readdata <= avs_read ? next_readdata : 32'h0000_0000;
      end
      else
      begin
         avs_waitrequest <= 1'b1;
      end
   end

   // Writes take effect at the edge that completes the transfer
   always_ff @(posedge ref_clk)
   begin
      if (sys_rst)
      begin
         func_select[0] <= SIFM_RST_SEL1; // R6
         func_select[1] <= SIFM_RST_SEL2; // R6
         func_select[2] <= SIFM_RST_SEL3; // R6
         func_select[3] <= SIFM_RST_SEL4; // R6
         func_select[4] <= SIFM_RST_SEL5; // R6
      end
      else if (bus_take && sel_hit && avs_byteenable[0])
      begin
         // Out-of-range codes are ignored
         // A negative code with zero low bits is -64 and must be refused
         if (avs_writedata[6] ?
             ((avs_writedata[5:0] != 6'h00) &&
              ((~avs_writedata[5:0] + 6'h01) <= SIFM_SEL_MAX)) :
             (avs_writedata[5:0] <= SIFM_SEL_MAX)) // R1
         begin
            func_select[sel_index] <= avs_writedata[6:0];
         end
      end
   end

   always_ff @(posedge ref_clk)
   begin
      if (sys_rst)
      begin
         limit_ignore_select <= SIFM_RST_LIMIT_IGNORE; // R8
         enable_source_select <= SIFM_RST_ENABLE_SOURCE; // R10
         enable_source_override <= SIFM_RST_ENABLE_OVERRIDE;
         fast_filter_enable <= SIFM_RST_FAST_FILTER_EN; // R12
         input_one_filter_time <= SIFM_RST_FILTER_TIME; // R13
         function_force_mask_one <= SIFM_RST_FORCE_MASK; // R14
      end
      else if (bus_take && avs_byteenable[0])
      begin
         case (avs_address)
            SIFM_OFS_LIMIT_IGNORE:
               limit_ignore_select <= avs_writedata[1:0];
            SIFM_OFS_ENABLE_SOURCE:
               enable_source_select <= avs_writedata[0];
            SIFM_OFS_ENABLE_OVERRIDE:
               enable_source_override <= avs_writedata[0];
            SIFM_OFS_FAST_FILTER_EN:
               fast_filter_enable <= avs_writedata[1:0];
            SIFM_OFS_FILTER_TIME:
            begin
               if (avs_byteenable[1] &&
                   avs_writedata[9:0] >= SIFM_FILTER_TIME_MIN &&
                   avs_writedata[9:0] <= SIFM_FILTER_TIME_MAX)
               begin
                  input_one_filter_time <= avs_writedata[9:0];
               end
            end
            SIFM_OFS_FORCE_MASK:
               function_force_mask_one <= avs_writedata[4:0];
            default:
            begin
            end
         endcase
      end
   end

   always_comb
   begin
      next_readdata = 32'h0000_0000;
      if (sel_hit)
      begin
         next_readdata = {{25{1'b0}}, func_select[sel_index]};
      end
      else
      begin
         case (avs_address)
            SIFM_OFS_LIMIT_IGNORE:
               next_readdata = {30'h0000_0000, limit_ignore_select};
            SIFM_OFS_ENABLE_SOURCE:
               next_readdata = {31'h0000_0000, enable_source_select};
            SIFM_OFS_ENABLE_OVERRIDE:
               next_readdata = {31'h0000_0000, enable_source_override};
            SIFM_OFS_FAST_FILTER_EN:
               next_readdata = {30'h0000_0000, fast_filter_enable};
            SIFM_OFS_FILTER_TIME:
               next_readdata = {22'h00_0000, input_one_filter_time};
            SIFM_OFS_FORCE_MASK:
               next_readdata = {27'h000_0000, function_force_mask_one};
            SIFM_OFS_STATUS:
               next_readdata = {21'h00_0000, motion, filtered_inputs};
            SIFM_OFS_FUNC_LOW:
               next_readdata = function_state[31:0];
            SIFM_OFS_FUNC_HIGH:
               next_readdata = {26'h000_0000, function_state[37:32]};
            default:
               next_readdata = 32'h0000_0000;
         endcase
      end
   end

   // 0.1 ms time base
   logic [TICK_W-1:0] tick_count;
   logic tick;

   always_ff @(posedge ref_clk)
   begin
      if (sys_rst)
      begin
         tick_count <= '0;
         tick <= 1'b0;
      end
      else if (tick_count == TICK_W'(TICK_CYCLES - 1))
      begin
         tick_count <= '0;
         tick <= 1'b1;
      end
      else
      begin
         tick_count <= tick_count + TICK_W'(1);
         tick <= 1'b0;
      end
   end

   // Three-stage synchronisers; a level is accepted once stages 2 and 3 agree
   logic [6:0] sync_a;
   logic [6:0] sync_b;
   logic [6:0] sync_c;
   logic [6:0] pin_level;
   logic [6:0] raw_pins;

   assign raw_pins = {fast_input_two, fast_input_one, general_input_raw};

   always_ff @(posedge ref_clk)
   begin
      if (sys_rst)
      begin
         sync_a <= 7'h00;
         sync_b <= 7'h00;
         sync_c <= 7'h00;
         pin_level <= 7'h00;
      end
      else
      begin
         sync_a <= raw_pins;
         sync_b <= sync_a;
         sync_c <= sync_b;
         for (int i = 0; i < 7; i++)
         begin
            if (sync_b[i] == sync_c[i])
            begin
               pin_level[i] <= sync_c[i];
            end
         end
      end
   end

   // General input filters: a change is taken after it holds for the
   // filter time counted in 0.1 ms ticks
   logic [4:0] gen_filt;
   logic [9:0] gen_count [SIFM_NUM_INPUTS];

   generate
      for (genvar g = 0; g < SIFM_NUM_INPUTS; g++)
      begin : gen_filter
         logic [9:0] limit;
         assign limit = (g == 0) ? input_one_filter_time
                                 : SIFM_RST_FILTER_TIME; // R13
         always_ff @(posedge ref_clk)
         begin
            if (sys_rst)
            begin
               gen_filt[g] <= 1'b0;
               gen_count[g] <= 10'h000;
            end
            else if (pin_level[g] == gen_filt[g])
            begin
               gen_count[g] <= 10'h000;
            end
            else if (tick)
            begin
               if (gen_count[g] + 10'h001 >= limit) // R15
               begin
                  gen_filt[g] <= pin_level[g]; // R16
                  gen_count[g] <= 10'h000;
               end
               else
               begin
                  gen_count[g] <= gen_count[g] + 10'h001;
               end
            end
         end
      end
   endgenerate

   // Fast input filters, bypassed at fast_input_one_out and fast_input_two_out while disabled
   logic [1:0] fast_filt;
   logic [FAST_W-1:0] fast_count [2];

   generate
      for (genvar f = 0; f < 2; f++)
      begin : fast_filter
         always_ff @(posedge ref_clk)
         begin
            if (sys_rst)
            begin
               fast_filt[f] <= 1'b0;
               fast_count[f] <= '0;
            end
            else if (pin_level[5 + f] == fast_filt[f])
            begin
               fast_count[f] <= '0;
            end
            else if (fast_count[f] ==
                     FAST_W'(SIFM_FAST_FILT_CYCLES - 1))
            begin
               fast_filt[f] <= pin_level[5 + f];
               fast_count[f] <= '0;
            end
            else
            begin
               fast_count[f] <= fast_count[f] + FAST_W'(1);
            end
         end
      end
   endgenerate

   always_ff @(posedge ref_clk)
   begin
      if (sys_rst)
      begin
         fast_input_one_out <= 1'b0;
         fast_input_two_out <= 1'b0;
      end
      else
      begin
         fast_input_one_out <= fast_filter_enable[0] ? fast_filt[0]
                                                     : pin_level[5]; // R12
         fast_input_two_out <= fast_filter_enable[1] ? fast_filt[1]
                                                     : pin_level[6]; // R12
      end
   end

   // Function mapping
   logic [37:0] next_function_state;
   logic [5:0] code;
   logic active;

   always_comb
   begin
      next_function_state = 38'h00_0000_0000; // R4
      code = 6'h00;
      active = 1'b0;
      for (int i = 0; i < SIFM_NUM_INPUTS; i++)
      begin
         code = func_select[i][6] ? (~func_select[i][5:0] + 6'h01)
                                  : func_select[i][5:0]; // R1
         active = gen_filt[i] ^ func_select[i][6]; // R2
         if (code != 6'h00)
         begin
            next_function_state[code] = next_function_state[code] |
                                        active; // R3
         end
      end
      if (function_force_mask_one[SIFM_FORCE_SERVO_ON_BIT]) // R5
      begin
         next_function_state[SIFM_FN_SERVO_ON] = 1'b1;
      end
      if (function_force_mask_one[SIFM_FORCE_ALARM_RESET_BIT]) // R5
      begin
         next_function_state[SIFM_FN_ALARM_RESET] = 1'b1;
      end
      if (function_force_mask_one[SIFM_FORCE_FWD_LIMIT_BIT]) // R14
      begin
         next_function_state[SIFM_FN_FWD_LIMIT] = 1'b1;
      end
      if (function_force_mask_one[SIFM_FORCE_REV_LIMIT_BIT]) // R14
      begin
         next_function_state[SIFM_FN_REV_LIMIT] = 1'b1;
      end
   end

   always_ff @(posedge ref_clk)
   begin
      if (sys_rst)
      begin
         function_state <= 38'h00_0000_0000;
         filtered_inputs <= '0;
      end
      else
      begin
         function_state <= next_function_state;
         filtered_inputs <= {fast_filt, gen_filt};
      end
   end

   // Motion permissions and servo enable
   always_ff @(posedge ref_clk)
   begin
      if (sys_rst)
      begin
         motion <= '0;
      end
      else
      begin
         motion.forward_allow <=
            limit_ignore_select[SIFM_IGNORE_FWD_BIT] | // R9
            next_function_state[SIFM_FN_FWD_LIMIT]; // R7
         motion.reverse_allow <=
            limit_ignore_select[SIFM_IGNORE_REV_BIT] | // R9
            next_function_state[SIFM_FN_REV_LIMIT]; // R7
         motion.alarm_reset <= next_function_state[SIFM_FN_ALARM_RESET];
         motion.servo_enable <=
            (enable_source_select & ~enable_source_override) | // R11
            next_function_state[SIFM_FN_SERVO_ON]; // R10
      end
   end

endmodule

// [testbench/sifm_field.sv]
module sifm_field
   import sifm_pkg::*;
(
   input wire sifm_inputs_type contact,
   output logic [4:0] general_input_raw,
   output logic fast_input_one,
   output logic fast_input_two
);
   timeunit 1ns;
   timeprecision 1ns;
   // A closed contact conducts and shows 1 at the pin
   assign general_input_raw = contact.general;
   assign fast_input_one = contact.fast[0];
   assign fast_input_two = contact.fast[1];
endmodule

// [testbench/sifm_mapper_sva.sv]
module sifm_mapper_chk
   import sifm_pkg::*;
#(
   parameter int TICK_CYCLES = SIFM_TICK_CYCLES
)
(
   input wire logic ref_clk,
   input wire logic sys_rst,
   input wire logic avs_read,
   input wire logic avs_write,
   input wire logic avs_waitrequest,
   input wire logic [4:0] general_input_raw,
   input wire sifm_inputs_type filtered_inputs,
   input wire sifm_motion_type motion,
   input wire logic [37:0] function_state
);
   timeunit 1ns;
   timeprecision 1ns;
   default clocking @(posedge ref_clk);
   endclocking
   default disable iff (sys_rst);
   sequence s_ans;
      !avs_waitrequest ##1 avs_waitrequest;
   endsequence
   property p_ans;
      (avs_read || avs_write) && avs_waitrequest |=> s_ans;
   endproperty
   property p_rst;
      $fell(sys_rst) |-> avs_waitrequest && function_state == '0;
   endproperty
   property p_fs0;
      function_state[0] == 1'b0;
   endproperty
   property p_fwd;
      function_state[3] |-> motion.forward_allow;
   endproperty
   property p_rev;
      function_state[4] |-> motion.reverse_allow;
   endproperty
   property p_son;
      function_state[1] |-> motion.servo_enable;
   endproperty
   property p_alarm_reset_request;
      motion.alarm_reset == function_state[2];
   endproperty
   property p_filt;
      $changed(filtered_inputs.general[1]) |->
         $past(general_input_raw[1], 4) == filtered_inputs.general[1];
   endproperty
   a_ans: assert property (p_ans) else $error("bus answer late");
   a_rst: assert property (p_rst) else $error("reset state");
   a_fs0: assert property (p_fs0) else $error("code zero set");
   a_fwd: assert property (p_fwd) else $error("forward blocked");
   a_rev: assert property (p_rev) else $error("reverse blocked");
   a_son: assert property (p_son) else $error("servo off");
   a_alarm_reset_request: assert property (p_alarm_reset_request) else $error("alarm reset");
   a_filt: assert property (p_filt) else $error("filter glitch");
endmodule

bind sifm_mapper sifm_mapper_chk #(.TICK_CYCLES(TICK_CYCLES)) u_chk (
   .ref_clk(ref_clk),
   .sys_rst(sys_rst),
   .avs_read(avs_read),
   .avs_write(avs_write),
   .avs_waitrequest(avs_waitrequest),
   .general_input_raw(general_input_raw),
   .filtered_inputs(filtered_inputs),
   .motion(motion),
   .function_state(function_state)
);

// [testbench/sifm_mapper_bench.sv]
module sifm_mapper_bench
   import sifm_pkg::*;
;
   timeunit 1ns;
   timeprecision 1ns;
   localparam int TK = 4;
   logic ref_clk = 1'b0;
   logic sys_rst = 1'b1;
   logic [7:0] avs_address = 8'h00;
   logic avs_read = 1'b0;
   logic avs_write = 1'b0;
   logic [31:0] avs_writedata = 32'h0;
   logic [31:0] avs_readdata;
   logic avs_waitrequest;
   logic [4:0] general_input_raw;
   logic fast_input_one;
   logic fast_input_two;
   logic fast_input_one_out;
   logic fast_input_two_out;
   sifm_inputs_type filtered_inputs;
   sifm_motion_type motion;
   logic [37:0] function_state;
   sifm_inputs_type cont = '0;
   int err_total = 0;
   int tests_run = 0;
   int cyc = 0;
   always #5 ref_clk = ~ref_clk;
   sifm_mapper #(.TICK_CYCLES(TK)) u_sifm_mapper (
      .ref_clk(ref_clk),
      .sys_rst(sys_rst),
      .avs_address(avs_address),
      .avs_read(avs_read),
      .avs_write(avs_write),
      .avs_writedata(avs_writedata),
      .avs_byteenable(4'hf),
      .avs_readdata(avs_readdata),
      .avs_waitrequest(avs_waitrequest),
      .general_input_raw(general_input_raw),
      .fast_input_one(fast_input_one),
      .fast_input_two(fast_input_two),
      .fast_input_one_out(fast_input_one_out),
      .fast_input_two_out(fast_input_two_out),
      .filtered_inputs(filtered_inputs),
      .motion(motion),
      .function_state(function_state)
   );
   sifm_field u_sifm_field (
      .contact(cont),
      .general_input_raw(general_input_raw),
      .fast_input_one(fast_input_one),
      .fast_input_two(fast_input_two)
   );
   task automatic test_done;
      $display("checks %0d mismatches %0d", tests_run, err_total);
      if (err_total == 0 && tests_run > 0)
         $display("TEST PASSED");
      else
         $display("TEST FAILED");
      $finish;
   endtask
   task automatic chk(input string s, input logic [37:0] e,
      input logic [37:0] g);
      tests_run++;
      if (g !== e)
      begin
         err_total++;
         $display("CHECK FAILED %s expected %h seen %h", s, e, g);
      end
   endtask
   task automatic bus(input logic w, input logic [7:0] a,
      input logic [31:0] d, output logic [31:0] q);
      avs_address <= a;
      avs_writedata <= d;
      avs_write <= w;
      avs_read <= !w;
      do
         @(posedge ref_clk);
      while (avs_waitrequest !== 1'b0);
      q = avs_readdata;
      avs_write <= 1'b0;
      avs_read <= 1'b0;
      @(posedge ref_clk);
   endtask
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      logic [31:0] q;
      bus(1'b1, a, d, q);
   endtask
   task automatic rd(input string s, input logic [7:0] a,
      input logic [37:0] e);
      logic [31:0] q;
      bus(1'b0, a, 32'h0, q);
      chk(s, e, {6'h0, q});
   endtask
   task automatic hold(input int n);
      repeat (n) @(posedge ref_clk);
   endtask
   task automatic t_reset;
      logic [7:0] ofs [12];
      logic [9:0] dv [12];
      ofs = '{8'h00, 8'h04, 8'h08, 8'h0c, 8'h10, 8'h14, 8'h18, 8'h1c,
         8'h20, 8'h24, 8'h28, 8'h40};
      dv = '{10'h004, 10'h003, 10'h017, 10'h000, 10'h000, 10'h003,
         10'h000, 10'h000, 10'h000, 10'h014, 10'h000, 10'h000};
      hold(1);
      chk("motion_rst", 38'hc, {34'h0, motion});
      for (int i = 0; i < 12; i++)
         rd("reset_value", ofs[i], {28'h0, dv[i]});
      wr(8'h40, 32'h1f);
      rd("unmapped", 8'h40, 38'h0);
      $display("t_reset done");
   endtask
   task automatic t_map;
      wr(8'h00, 32'h01);
      wr(8'h04, 32'h7f);
      wr(8'h08, 32'h25);
      hold(100);
      chk("neg_open", 38'h2, function_state);
      cont.general <= 5'b00110;
      hold(100);
      chk("pos_closed", 38'h20_0000_0000, function_state);
      cont.general <= 5'b00111;
      hold(100);
      chk("or_merge", 38'h20_0000_0002, function_state);
      wr(8'h00, 32'h26);
      rd("sel_range", 8'h00, 38'h1);
      wr(8'h00, 32'h40);
      rd("sel_neg_range", 8'h00, 38'h1);
      cont.general <= 5'b00000;
      hold(100);
      $display("t_map done");
   endtask
   task automatic t_limit;
      for (int i = 0; i < 4; i++)
      begin
         wr(8'h14, 32'(i));
         hold(3);
         chk("ignore", 38'(i[1:0]), {36'h0, motion[3:2]});
      end
      wr(8'h14, 32'h0);
      wr(8'h0c, 32'h03);
      wr(8'h10, 32'h7c);
      hold(100);
      chk("limit_open", 38'h2, {36'h0, motion[3:2]});
      cont.general <= 5'b01000;
      hold(100);
      chk("limit_closed", 38'h3, {36'h0, motion[3:2]});
      $display("t_limit done");
   endtask
   task automatic t_force;
      wr(8'h04, 32'h0);
      cont.general <= 5'b00000;
      hold(100);
      chk("unselected", 38'h10, function_state);
      wr(8'h28, 32'h1e);
      hold(3);
      chk("forced", 38'h1e, function_state);
      chk("motion_forced", 38'hf, {34'h0, motion});
      wr(8'h28, 32'h01);
      hold(3);
      chk("unused_bit", 38'h10, function_state);
      wr(8'h18, 32'h1);
      hold(3);
      chk("sw_enable", 38'h1, {37'h0, motion.servo_enable});
      wr(8'h1c, 32'h1);
      hold(3);
      chk("override", 38'h0, {37'h0, motion.servo_enable});
      wr(8'h18, 32'h0);
      wr(8'h1c, 32'h0);
      $display("t_force done");
   endtask
   task automatic t_fast;
      logic [1:0] seen;
      wr(8'h20, 32'h1);
      seen = 2'h0;
      cont.fast <= 2'h3;
      hold(3);
      cont.fast <= 2'h0;
      repeat (12)
      begin
         @(posedge ref_clk);
         seen = seen | {fast_input_two_out, fast_input_one_out};
      end
      chk("fast_pulse", 38'h2, {36'h0, seen});
      cont.fast <= 2'h3;
      hold(12);
      chk("fast_hold", 38'h3,
         38'({fast_input_two_out, fast_input_one_out}));
      cont.fast <= 2'h0;
      hold(12);
      $display("t_fast done");
   endtask
   task automatic t_ftime(input int n);
      int c;
      wr(8'h24, 32'(n));
      c = 0;
      cont.general[0] <= 1'b1;
      while (filtered_inputs.general[0] !== 1'b1)
      begin
         @(posedge ref_clk);
         c++;
      end
      chk("ftime_min", 38'h1, 38'(c >= (n - 1) * TK));
      chk("ftime_max", 38'h1, 38'(c <= n * TK + 10));
      cont.general[0] <= 1'b0;
      hold(n * TK + 20);
      $display("t_ftime done");
   endtask
   always @(posedge ref_clk)
   begin
      cyc <= cyc + 1;
      if (cyc == 20000)
      begin
         err_total++;
         test_done;
      end
   end
   initial
   begin
      repeat (10) @(posedge ref_clk);
      sys_rst <= 1'b0;
      @(posedge ref_clk);
      t_reset;
      t_map;
      t_limit;
      t_force;
      t_fast;
      t_ftime(20);
      t_ftime(2);
      wr(8'h24, 32'h0);
      rd("ftime_range", 8'h24, 38'h2);
      test_done;
   end
endmodule
